// ===== logic/asfc_pkg.sv
// Purpose: shared constants and types of the conversion flow control block
// Assumes: Avalon-MM slave with 32-bit data, word addressing in bytes
// Notes: offsets are byte addresses of aligned words, except the enable register at byte 6
package asfc_pkg;

  // ****************************************
  // register map
  // ****************************************
  localparam int ASFC_AW = 8;                        // byte address width
  localparam logic [7:0] ASFC_OFF_CTL0 = 8'h00;      // converter_control_zero
  localparam logic [7:0] ASFC_OFF_EIE = 8'h06;       // error_irq_enable byte offset
  localparam logic [7:0] ASFC_OFF_FLOW = 8'h08;      // flow_control_reg
  localparam logic [7:0] ASFC_OFF_STAT = 8'h0C;      // status flags
  localparam logic [7:0] ASFC_OFF_CMD = 8'h40;       // command list base
  localparam int ASFC_IDX_TO_BYTE = 4;               // index to byte scale

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int ASFC_ACC_LSB = 10;                  // access_path_select [11:10]
  localparam int ASFC_STR_BIT = 9;                   // abort_result_store
  localparam int ASFC_MOD_BIT = 8;                   // flow_mode_select
  localparam logic [7:0] ASFC_EIE_MASK = 8'hEE;      // bits 4 and 0 reserved
  localparam logic [15:0] ASFC_CTL0_RST = 16'h0000;
  localparam logic [7:0] ASFC_EIE_RST = 8'h00;
  localparam int ASFC_LIST_MAX = 64;                 // commands per list
  localparam int ASFC_CONV_CYC = 4;                  // cycles per conversion

  // flow control word bits
  localparam int ASFC_FL_SEQUENCE_ABORT_FLAG = 3;
  localparam int ASFC_FL_TRIG = 2;
  localparam int ASFC_FL_RSTA = 1;
  localparam int ASFC_FL_LDOK = 0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    ASFC_CMD_NORMAL = 2'h0,
    ASFC_CMD_EOS    = 2'h1,
    ASFC_CMD_EOL    = 2'h2,
    ASFC_CMD_RSV    = 2'h3
  } asfc_cmd_type_t;

  typedef enum logic [1:0] {
    ASFC_ACC_NONE = 2'h0,
    ASFC_ACC_INT  = 2'h1,
    ASFC_ACC_BUS  = 2'h2,
    ASFC_ACC_DUAL = 2'h3
  } asfc_acc_t;

  typedef enum {ASFC_IDLE, ASFC_CONV, ASFC_WAIT} asfc_state_t;

  // internal interface event group
  typedef struct packed {
    logic trigger;
    logic restart;
    logic abort;
    logic load_ok;
  } asfc_evt_t;

  // conversion result handed on to the result store
  typedef struct packed {
    logic valid;
    logic [5:0] index;
    logic [15:0] data;
  } asfc_res_t;

endpackage

// ===== logic/asfc_top.sv
// Purpose: conversion flow control of the converter: access path, sequence run,
//   abort and restart handling, error interrupt enables
// Assumes: one clock, synchronous reset, events are one-cycle pulses
// Notes: the converter core itself is modelled by a fixed conversion time
//
// Notes on behaviour
// - access path field selects flow register writers
// - reset leaves no access path enabled
// - store bit low drops aborted conversion
// - early lone restart flags error, sets abort
// - store bit high keeps aborted conversion result
// - store bit high never sets restart error
// - flow mode bit: restart or trigger mode
// - error enable register at offset six, always
// - enable bits 7,6,5 for access, command, list
// - enable bits 3,2,1 for trigger, restart, load
// - list holds at most sixty-four commands
// - trigger runs sequence until end marker
module asfc_top #(
  parameter int LIST_LEN = asfc_pkg::ASFC_LIST_MAX,
  parameter int CONV_CYC = asfc_pkg::ASFC_CONV_CYC
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [asfc_pkg::ASFC_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire asfc_pkg::asfc_evt_t int_evt,
  input wire logic [15:0] conv_data,
  output asfc_pkg::asfc_res_t conv_result,
  output logic [5:0] conv_channel,
  output logic conv_busy,
  output logic [7:0] irq_enable
);
  import asfc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic ack;                       // bus answer pending
    logic [31:0] rdata;              // read data register
    logic [15:0] ctl0;               // converter_control_zero
    logic [7:0] eie;                 // error_irq_enable
    logic sequence_abort_flag;                      // sequence_abort_flag
    logic trig;                      // trigger flag of flow register
    logic rsta;                      // restart flag of flow register
    logic ldok;                      // load ok flag of flow register
    logic restart_error_flag;        // sticky restart error
    logic eol_error;                 // end of list reached by run past end
    asfc_state_t fsm;
    logic [5:0] ptr;                 // current command index
    logic [7:0] cnt;                 // conversion timer
    asfc_res_t res;
  } asfc_st_t;

  asfc_st_t st;
  asfc_st_t next_st;
  logic [1:0] cmd_type [LIST_LEN]; // command list type fields
  logic [5:0] cmd_chan [LIST_LEN]; // command list channel fields

  // ****************************************
  // helpers
  // ****************************************
  // decode shared by bus write and read
  function automatic logic hit(input logic [ASFC_AW-1:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // command list window decode, used by write and read paths
  // no output argument: the call sits in a continuous assignment
  function automatic logic cmd_hit(input logic [ASFC_AW-1:0] a);
    logic [ASFC_AW-1:0] rel;
    rel = a - ASFC_OFF_CMD;
    return (a >= ASFC_OFF_CMD) && (int'(rel[7:2]) < LIST_LEN);
  endfunction

  // word index of a command list address
  // limitation: an 8-bit byte address reaches only 48 list words above
  //   the list base, entries beyond stay at their reset end of list
  function automatic logic [5:0] cmd_index(input logic [ASFC_AW-1:0] a);
    logic [ASFC_AW-1:0] rel;
    rel = a - ASFC_OFF_CMD;
    return rel[7:2];
  endfunction

  logic [5:0] wr_idx;
  logic [5:0] rd_idx;
  logic wr_cmd;
  logic rd_cmd;
  logic bus_wr;
  logic bus_rd;
  asfc_acc_t acc;
  logic bus_flow_ok;
  logic int_flow_ok;
  logic last_cmd;
  logic conv_done;
  logic [7:0] conv_cyc_m1;

  assign conv_cyc_m1 = 8'(CONV_CYC - 1);
  // writes land on the answer edge, when waitrequest is low, so that
  //   a master which drops its request early leaves no trace
  assign bus_wr = avs_write && st.ack;
  // reads fetch on the first edge so the data stand at the answer edge
  assign bus_rd = avs_read && !st.ack;
  assign wr_cmd = cmd_hit(avs_address);
  assign rd_cmd = cmd_hit(avs_address);
  assign wr_idx = cmd_index(avs_address);
  assign rd_idx = cmd_index(avs_address);
  assign acc = asfc_acc_t'(st.ctl0[ASFC_ACC_LSB +: 2]);
  // access path gating of the flow register
  assign bus_flow_ok = (acc == ASFC_ACC_BUS) || (acc == ASFC_ACC_DUAL);
  assign int_flow_ok = (acc == ASFC_ACC_INT) || (acc == ASFC_ACC_DUAL);
  // end of sequence or list ends the run
  assign last_cmd = (cmd_type[st.ptr] == ASFC_CMD_EOS)
                 || (cmd_type[st.ptr] == ASFC_CMD_EOL);
  assign conv_done = (st.fsm == ASFC_CONV) && (st.cnt == conv_cyc_m1);

  // ****************************************
  // command list storage
  // ****************************************
  // software fills the list; bound to LIST_LEN words
  // entries come up as end of list, so a run with no setup stops after its first conversion
  generate
    for (genvar i = 0; i < LIST_LEN; i++) begin : g_cmd
      always_ff @(posedge sys_clk) begin
        if (srst) begin
          cmd_type[i] <= ASFC_CMD_EOL;
          cmd_chan[i] <= 6'h00;
        end else if (bus_wr && wr_cmd && (int'(wr_idx) == i) && avs_byteenable[0]) begin
          cmd_type[i] <= avs_writedata[7:6];
          cmd_chan[i] <= avs_writedata[5:0];
        end
      end
    end
  endgenerate

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    logic ev_trig;
    logic ev_rsta;
    logic ev_abort;
    logic ev_ldok;
    logic store;
    logic [15:0] wmask;
    ev_trig = 1'b0;
    ev_rsta = 1'b0;
    ev_abort = 1'b0;
    ev_ldok = 1'b0;
    store = st.ctl0[ASFC_STR_BIT];
    wmask = 16'h0000;
    next_st = st;
    next_st.ack = avs_read || avs_write ? !st.ack : 1'b0;
    next_st.res.valid = 1'b0;

    // bus writes to configuration registers
    if (bus_wr) begin
      wmask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
      if (hit(avs_address, ASFC_OFF_CTL0)) begin
        next_st.ctl0 = (st.ctl0 & ~wmask) | (avs_writedata[15:0] & wmask);
      end
      // writable at any time, reserved bits dropped
      if (hit(avs_address, ASFC_OFF_EIE) && avs_byteenable[0]) begin
        next_st.eie = avs_writedata[7:0] & ASFC_EIE_MASK;
      end
      if (hit(avs_address, ASFC_OFF_FLOW) && bus_flow_ok && avs_byteenable[0]) begin
        ev_trig = avs_writedata[ASFC_FL_TRIG];
        ev_rsta = avs_writedata[ASFC_FL_RSTA];
        ev_abort = avs_writedata[ASFC_FL_SEQUENCE_ABORT_FLAG];
        ev_ldok = avs_writedata[ASFC_FL_LDOK];
      end
      // status is write one to clear
      if (hit(avs_address, ASFC_OFF_STAT) && avs_byteenable[0]) begin
        if (avs_writedata[0]) next_st.restart_error_flag = 1'b0;
        if (avs_writedata[1]) next_st.eol_error = 1'b0;
      end
    end
    // internal interface events, gated by path
    if (int_flow_ok) begin
      ev_trig = ev_trig | int_evt.trigger;
      ev_rsta = ev_rsta | int_evt.restart;
      ev_abort = ev_abort | int_evt.abort;
      ev_ldok = ev_ldok | int_evt.load_ok;
    end
    if (ev_ldok) next_st.ldok = 1'b1;

    // sequence engine
    unique case (st.fsm)
      ASFC_IDLE, ASFC_WAIT: begin
        if (ev_rsta) begin
          // restart: rewind list, restart mode starts at once
          next_st.ptr = 6'h00;
          next_st.rsta = 1'b0;
          next_st.sequence_abort_flag = 1'b0;
          next_st.ldok = 1'b0;
          if (!st.ctl0[ASFC_MOD_BIT]) begin
            next_st.fsm = ASFC_CONV;
            next_st.cnt = 8'h00;
          end else begin
            next_st.fsm = ASFC_WAIT;
          end
        end else if (ev_trig && st.fsm == ASFC_WAIT) begin
          next_st.fsm = ASFC_CONV;
          next_st.cnt = 8'h00;
          next_st.trig = 1'b0;
        end else if (ev_trig) begin
          next_st.trig = 1'b1; // trigger while idle is held
        end
      end
      ASFC_CONV: begin
        next_st.cnt = st.cnt + 8'h01;
        if (ev_abort || ev_rsta) begin
          // conversion cut short
          if (store) begin
            next_st.res = '{valid: 1'b1, index: st.ptr, data: conv_data};
          end // else data dropped and flag kept low
          if (ev_rsta && !ev_abort && !st.sequence_abort_flag && !store) begin
            next_st.restart_error_flag = 1'b1;
            next_st.sequence_abort_flag = 1'b1;
          end // store high leaves error flag alone
          if (ev_abort) next_st.sequence_abort_flag = 1'b1;
          next_st.ptr = 6'h00;
          next_st.cnt = 8'h00;
          next_st.fsm = (ev_rsta && !st.ctl0[ASFC_MOD_BIT]) ? ASFC_CONV : ASFC_WAIT;
        end else if (conv_done) begin
          next_st.res = '{valid: 1'b1, index: st.ptr, data: conv_data};
          next_st.cnt = 8'h00;
          if (cmd_type[st.ptr] == ASFC_CMD_EOL) begin
            // end of list: restart mode waits for restart, trigger mode wraps
            next_st.ptr = 6'h00;
            next_st.fsm = st.ctl0[ASFC_MOD_BIT] ? ASFC_WAIT : ASFC_IDLE;
          end else if (last_cmd) begin
            next_st.ptr = st.ptr + 6'h01;
            next_st.fsm = ASFC_WAIT;
          end else if (int'(st.ptr) == LIST_LEN - 1) begin
            // ran off the list without a marker
            next_st.eol_error = 1'b1;
            next_st.ptr = 6'h00;
            next_st.fsm = ASFC_IDLE;
          end else begin
            next_st.ptr = st.ptr + 6'h01;
          end
        end
      end
    endcase

    // bus read data
    next_st.rdata = 32'h0000_0000;
    if (bus_rd) begin
      if (hit(avs_address, ASFC_OFF_CTL0)) next_st.rdata[15:0] = st.ctl0;
      else if (hit(avs_address, ASFC_OFF_EIE)) next_st.rdata[7:0] = st.eie;
      else if (hit(avs_address, ASFC_OFF_FLOW)) begin
        next_st.rdata[ASFC_FL_SEQUENCE_ABORT_FLAG] = st.sequence_abort_flag;
        next_st.rdata[ASFC_FL_TRIG] = st.trig;
        next_st.rdata[ASFC_FL_RSTA] = st.rsta;
        next_st.rdata[ASFC_FL_LDOK] = st.ldok;
      end else if (hit(avs_address, ASFC_OFF_STAT)) begin
        next_st.rdata[1:0] = {st.eol_error, st.restart_error_flag};
        next_st.rdata[4:2] = {st.fsm == ASFC_CONV, st.fsm == ASFC_WAIT, st.sequence_abort_flag};
        next_st.rdata[13:8] = st.ptr;
      end else if (rd_cmd) begin
        next_st.rdata[7:0] = {cmd_type[rd_idx], cmd_chan[rd_idx]};
      end
    end
  end

  // ****************************************
  // state register
  // ****************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      st <= '0;
      st.ctl0 <= ASFC_CTL0_RST;
      st.eie <= ASFC_EIE_RST;
      st.fsm <= ASFC_IDLE;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  // one wait cycle per access, answer on the second edge
  assign avs_waitrequest = (avs_read || avs_write) && !st.ack;
  assign avs_readdata = st.rdata;
  assign conv_result = st.res;
  // channel of the command under the pointer, straight from the list flops
  assign conv_channel = cmd_chan[st.ptr];
  // busy follows the registered state, so it never glitches
  assign conv_busy = (st.fsm == ASFC_CONV);
  assign irq_enable = st.eie;
endmodule

// ===== testbench/asfc_evt_src.sv
// Purpose: stand-in for the internal event source and converter data path
// Assumes: events are one-cycle pulses launched just after a rising edge
// Notes: conv_data moves every cycle so a stale sample cannot pass
module asfc_evt_src
  import asfc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic srst,
  output asfc_pkg::asfc_evt_t evt,
  output logic [15:0] conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  initial evt = '0;
  initial conv_data = 16'hACE1;
  // ****************************************
  // data pattern, changes every cycle
  // ****************************************
  always @(posedge sys_clk) begin
    conv_data <= {conv_data[14:0], conv_data[15] ^ conv_data[13] ^ 1'b1};
  end
  // one pulse, released at the next edge
  task automatic pulse(input asfc_evt_t e);
    @(posedge sys_clk);
    evt <= srst ? '0 : e;
    @(posedge sys_clk);
    evt <= '0;
  endtask
endmodule

// ===== testbench/asfc_checker.sv
// Purpose: port-level checks of the flow control block
// Assumes: one clock, synchronous active-high reset
// Notes: bound to asfc_top after the module
module asfc_checker
  import asfc_pkg::*;
#(
  parameter int LIST_LEN = 64
) (
  input wire logic sys_clk,
  input wire logic srst,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  input wire logic avs_waitrequest,
  input wire asfc_pkg::asfc_res_t conv_result,
  input wire logic conv_busy,
  input wire logic [7:0] irq_enable
);
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (srst);
  // accepted write to the enable register
  sequence s_eie_wr;
    avs_write && !avs_waitrequest && avs_address == ASFC_OFF_EIE && avs_byteenable[0];
  endsequence
  // request still waiting
  sequence s_req_wait;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  chk_reset_clear: assert property (disable iff (1'b0) srst |=> irq_enable == 8'h00)
    else $error("enables not cleared by reset");
  chk_eie_write: assert property (s_eie_wr |=> irq_enable == ($past(avs_writedata[7:0]) & ASFC_EIE_MASK))
    else $error("enable register write lost");
  chk_eie_hold: assert property (!s_eie_wr |=> $stable(irq_enable))
    else $error("enable register changed without write");
  chk_eie_rsvd: assert property (irq_enable[4] == 1'b0 && irq_enable[0] == 1'b0)
    else $error("reserved enable bit set");
  chk_wait_one: assert property (s_req_wait |=> !avs_waitrequest)
    else $error("more than one wait state");
  chk_res_pulse: assert property (conv_result.valid |=> !conv_result.valid)
    else $error("result valid longer than a cycle");
  chk_res_busy: assert property (conv_result.valid |-> $past(conv_busy))
    else $error("result without conversion");
  chk_res_index: assert property (conv_result.valid |-> conv_result.index < LIST_LEN)
    else $error("result index beyond list");
endmodule
bind asfc_top asfc_checker #(.LIST_LEN(LIST_LEN)) u_chk (.sys_clk(sys_clk), .srst(srst),
  .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
  .avs_waitrequest(avs_waitrequest), .conv_result(conv_result), .conv_busy(conv_busy),
  .irq_enable(irq_enable));

// ===== testbench/asfc_top_test.sv
// Purpose: self-checking bench of the flow control block
// Assumes: one wait state per bus access, list entries reset to end of list
// Notes: event source model drives the internal interface
module asfc_top_test;
  import asfc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, srst, avs_read, avs_write, avs_waitrequest, conv_busy, seen;
  logic [7:0] avs_address, irq_enable;
  logic [3:0] avs_byteenable, be;
  logic [31:0] avs_writedata, avs_readdata, q, d;
  logic [15:0] conv_data, prev_data;
  logic [5:0] last_idx, conv_channel;
  asfc_evt_t int_evt;
  asfc_res_t conv_result;
  int err_total, num_checks, res_cnt, n, i, seed;
  asfc_top u_asfc_top (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .int_evt(int_evt), .conv_data(conv_data), .conv_result(conv_result),
    .conv_channel(conv_channel), .conv_busy(conv_busy), .irq_enable(irq_enable));
  asfc_evt_src u_src (.sys_clk(sys_clk), .srst(srst), .evt(int_evt), .conv_data(conv_data));
  // ****************************************
  // clock, monitor, watchdog
  // ****************************************
  initial begin
    sys_clk = 0;
    forever #4 sys_clk = ~sys_clk;
  end
  // results and busy seen at the port
  always @(posedge sys_clk) begin
    if (conv_busy === 1'b1) seen = 1;
    if (conv_result.valid === 1'b1) begin
      res_cnt++;
      last_idx = conv_result.index;
      chk(conv_result.data, prev_data, "result data");
    end
    prev_data = conv_data;
  end
  // far above the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    complete_run();
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one bus access, held until waitrequest low
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge sys_clk);
    avs_address <= a;
    avs_writedata <= v;
    avs_byteenable <= be;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 0;
    avs_read <= 0;
  endtask
  task automatic rst(input int c);
    srst <= 1;
    repeat (c) @(posedge sys_clk);
    srst <= 0;
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    seed = 32'h6E1891B7;
    {srst, avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} = '0;
    be = 4'hF;
    {err_total, num_checks, res_cnt, seen} = '0;
    rst(8);
    bus(0, ASFC_OFF_CTL0, 0); chk(q, 0, "control reset");
    bus(0, ASFC_OFF_EIE, 0); chk(q, 0, "enable reset");
    bus(0, 8'h30, 0); chk(q, 0, "unmapped read");
    be = 4'h2; bus(1, ASFC_OFF_CTL0, 32'h00FF03FF);
    bus(0, ASFC_OFF_CTL0, 0); chk(q, 32'h0300, "control lane write");
    bus(1, ASFC_OFF_EIE, 32'hFF);
    bus(0, ASFC_OFF_EIE, 0); chk(q, 0, "enable lane ignored");
    be = 4'hF;
    for (i = 0; i < 8; i++) begin
      d = (i < 2) ? {32{i[0]}} : $random(seed);
      bus(1, ASFC_OFF_EIE, d);
      bus(0, ASFC_OFF_EIE, 0); chk(q, {24'h0, d[7:0] & 8'hEE}, "enable readback");
      chk(irq_enable, d[7:0] & 8'hEE, "enable port");
    end
    $display("enable register test done");
    for (i = 0; i < 4; i++) begin
      rst(2);
      bus(1, ASFC_OFF_CTL0, i << 10);
      seen = 0; u_src.pulse(4'b0100); repeat (20) @(posedge sys_clk);
      chk(seen, i[0], "internal path");
      seen = 0; bus(1, ASFC_OFF_FLOW, 32'h2); repeat (20) @(posedge sys_clk);
      chk(seen, i[1], "bus path");
    end
    $display("access path test done");
    for (i = 0; i < 2; i++) begin
      rst(2);
      bus(1, ASFC_OFF_CMD, 32'h05);
      bus(1, ASFC_OFF_CMD + 4, 32'h89);
      bus(1, ASFC_OFF_CTL0, 32'hC00 | (i << 9));
      u_src.pulse(4'b0100); n = res_cnt; u_src.pulse(4'b0100);
      repeat (2) @(posedge sys_clk);
      chk(res_cnt - n, i, "aborted result");
      if (i == 1) chk(last_idx, 0, "aborted index");
      bus(0, ASFC_OFF_STAT, 0); chk(q[0], !i[0], "restart error");
      if (i == 0) chk(q[2], 1, "abort flag");
    end
    $display("store test done");
    for (i = 0; i < 2; i++) begin
      rst(2);
      bus(1, ASFC_OFF_CMD, 32'h05);
      bus(1, ASFC_OFF_CMD + 4, 32'h49);
      bus(1, ASFC_OFF_CMD + 8, 32'h83);
      bus(1, ASFC_OFF_CTL0, 32'hC00 | (i << 8));
      n = res_cnt; u_src.pulse(4'b0100); repeat (40) @(posedge sys_clk);
      chk(res_cnt - n, i ? 0 : 2, "restart flow");
      if (i == 1) begin
        chk(conv_channel, 5, "first channel");
        n = res_cnt; u_src.pulse(4'b1000); repeat (40) @(posedge sys_clk);
        chk(res_cnt - n, 2, "first sequence");
        chk(last_idx, 1, "first sequence end");
        chk(conv_channel, 3, "next channel");
        n = res_cnt; u_src.pulse(4'b1000); repeat (40) @(posedge sys_clk);
        chk(res_cnt - n, 1, "last sequence");
        chk(last_idx, 2, "list end");
      end
    end
    $display("flow mode test done");
    complete_run();
  end
endmodule
